/* dv/dcsto_chk.sv */
// Purpose: Assertions on the ports of the torque shutdown block.
// Assumes: Bound to the top instance with its filter length.
// Notes:   Trip on A is judged on a count of its low samples.
`timescale 1ns/1ns
module dcsto_chk #(parameter int unsigned FILT_CYCLES = 4) (
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic chan_a_ok,
  input wire logic chan_b_ok,
  input wire logic fault_reset,
  input wire logic enable_req,
  input wire logic quick_stop_req,
  input wire logic amp_enable,
  input wire logic brake_cmd,
  input wire logic decel_req,
  input wire logic fault
);
  logic [7:0] lo_q;
  always_ff @(posedge clk_sys or posedge rst)
    if (rst) lo_q <= 8'h00;
    else lo_q <= chan_a_ok ? 8'h00 : lo_q + {7'h00, lo_q != 8'hff};
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (rst);
  sequence s_pulse;
    !fault && chan_b_ok && $fell(chan_a_ok) ##3 (chan_a_ok && chan_b_ok) [*4];
  endsequence
  AST_NO_BRAKE: assert property (!brake_cmd)
    else $error("brake used");
  AST_TRIP_A: assert property (
    lo_q > FILT_CYCLES + 2 |-> fault && !amp_enable)
    else $error("no trip on a");
  AST_TRIP_B: assert property (
    (!chan_b_ok) [*8] |-> fault && !amp_enable)
    else $error("no trip on b");
  AST_PULSE: assert property (s_pulse |-> !fault)
    else $error("pulse tripped");
  AST_HOLD: assert property ((!fault_reset) [*3] ##0 fault |=> fault)
    else $error("fault dropped");
  AST_OFF: assert property (fault |-> !amp_enable)
    else $error("amp on in fault");
  AST_START: assert property (
    $rose(amp_enable) |-> $past(enable_req) && !fault)
    else $error("bad restart");
  AST_QSTOP: assert property (
    quick_stop_req && amp_enable && chan_a_ok && chan_b_ok
    |-> ##[1:2] (decel_req || !amp_enable))
    else $error("no decel");
  AST_COAST: assert property (fault [*2] |-> !decel_req)
    else $error("decel after trip");
endmodule : dcsto_chk

/* dv/dcsto_estop.sv */
// Purpose: E-stop module and fieldbus master as seen from the drive.
// Assumes: stop_cmd is the operator pressing the stop switch.
// Notes:   One cut feeds both channels, so they never skew.
`timescale 1ns/1ns
module dcsto_estop #(parameter int unsigned DELAY = 8) (
  input  wire logic clk_sys,
  input  wire logic stop_cmd,
  output logic      chan_ok,
  output logic      quick_stop_req
);
  logic [7:0] dly_q = 8'h00;
  assign quick_stop_req = stop_cmd;
  assign chan_ok        = dly_q < 8'(DELAY);
  always_ff @(posedge clk_sys)
    dly_q <= stop_cmd ? dly_q + {7'h00, chan_ok} : 8'h00;
endmodule : dcsto_estop

/* dv/testbench.sv */
// Purpose: Directed bench for the torque shutdown block.
// Assumes: Short filter and skew counts keep the run brief.
// Notes:   Test pulses come from the bench, the e-stop from the model.
`timescale 1ns/1ns
module testbench;
  logic clk_sys = 1'b0, rst = 1'b1, enable_req = 1'b0, fault_reset = 1'b0;
  logic stop_cmd = 1'b0, a_ok = 1'b1, b_ok = 1'b1, m_ok, quick_stop_req;
  logic amp_enable, brake_cmd, decel_req, fault, skew_fault;
  int   n_errors = 0, comparisons = 0;
  always #50 clk_sys = ~clk_sys;
  dcsto_estop i_dcsto_estop (.clk_sys, .stop_cmd, .chan_ok(m_ok),
    .quick_stop_req);
  dcsto_top #(.FILT_CYCLES(4), .SKEW_CYCLES(50)) i_dcsto_top (.clk_sys,
    .rst, .chan_a_ok(m_ok & a_ok), .chan_b_ok(m_ok & b_ok), .fault_reset,
    .enable_req, .quick_stop_req, .amp_enable, .brake_cmd, .decel_req,
    .fault, .skew_fault);
  task automatic cyc(int n);
    repeat (n) @(posedge clk_sys);
  endtask : cyc
  task automatic chk(string nm, logic s, logic e);
    comparisons++;
    if (s !== e) begin
      n_errors++;
      $display("BAD %s exp %b seen %b", nm, e, s);
    end
  endtask : chk
  // Looks just after the edge so registered outputs have settled.
  task automatic look(logic amp, logic flt, logic dec);
    #1;
    chk("amp_enable", amp_enable, amp);
    chk("fault", fault, flt);
    chk("decel_req", decel_req, dec);
    @(posedge clk_sys);
  endtask : look
  task automatic clear_fault();
    fault_reset <= 1'b1;
    cyc(1);
    fault_reset <= 1'b0;
    cyc(6);
    look(1'b1, 1'b0, 1'b0);
  endtask : clear_fault
  task automatic t_power_up();
    cyc(12);
    rst <= 1'b0;
    cyc(4);
    look(1'b0, 1'b0, 1'b0);
    enable_req <= 1'b1;
    cyc(4);
    look(1'b1, 1'b0, 1'b0);
    $display("power_up done");
  endtask : t_power_up
  task automatic t_pulse();
    a_ok <= 1'b0;
    cyc(3);
    a_ok <= 1'b1;
    cyc(6);
    look(1'b1, 1'b0, 1'b0);
    $display("pulse done");
  endtask : t_pulse
  task automatic t_trip(logic on_b);
    a_ok <= on_b;
    b_ok <= !on_b;
    cyc(8);
    look(1'b0, 1'b1, 1'b0);
    {a_ok, b_ok} <= 2'b11;
    cyc(4);
    look(1'b0, 1'b1, 1'b0);
    clear_fault();
    $display("trip done");
  endtask : t_trip
  task automatic t_cat1();
    stop_cmd <= 1'b1;
    cyc(3);
    look(1'b1, 1'b0, 1'b1);
    cyc(12);
    look(1'b0, 1'b1, 1'b0);
    stop_cmd <= 1'b0;
    cyc(2);
    clear_fault();
    $display("cat1 done");
  endtask : t_cat1
  task automatic t_skew();
    a_ok <= 1'b0;
    cyc(60);
    #1;
    chk("skew_fault", skew_fault, 1'b1);
    look(1'b0, 1'b1, 1'b0);
    a_ok <= 1'b1;
    cyc(4);
    clear_fault();
    #1;
    chk("skew_fault", skew_fault, 1'b0);
    $display("skew done");
  endtask : t_skew
  task automatic give_verdict();
    $display("checks %0d errors %0d", comparisons, n_errors);
    if (n_errors == 0 && comparisons > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask : give_verdict
  initial begin
    t_power_up();
    t_pulse();
    t_trip(1'b0);
    t_trip(1'b1);
    t_cat1();
    t_skew();
    give_verdict();
  end
  initial begin
    cyc(2000);
    n_errors++;
    give_verdict();
  end
endmodule : testbench
bind dcsto_top dcsto_chk #(.FILT_CYCLES(FILT_CYCLES)) i_dcsto_chk (.clk_sys,
  .rst, .chan_a_ok, .chan_b_ok, .fault_reset, .enable_req, .quick_stop_req,
  .amp_enable, .brake_cmd, .decel_req, .fault);

/* verilog/dcsto_pkg.sv */
// Purpose: Shared constants and types for the dual channel torque shutdown.
// Assumes: 10 MHz system clock.
// Notes:   Times are kept in their own units; cycle counts derive from them.
package dcsto_pkg;

  // ******************************************************************
  // Timing
  // ******************************************************************
  localparam int unsigned CLK_HZ          = 10_000_000;
  localparam int unsigned PULSE_US        = 1000;
  localparam int unsigned RESPONSE_MS     = 50;
  localparam int unsigned SKEW_MS         = 1000;
  // Glitch filter: a low level must outlast the longest allowed pulse.
  localparam int unsigned PULSE_CYC       = (PULSE_US * (CLK_HZ / 1000)) / 1000;
  localparam int unsigned FILT_CYC        = PULSE_CYC + 1;
  localparam int unsigned RESPONSE_CYC    =
      (RESPONSE_MS * (CLK_HZ / 1000));
  localparam int unsigned SKEW_CYC        = SKEW_MS * (CLK_HZ / 1000);
  localparam int unsigned CNT_W           = 24;

  // ******************************************************************
  // Types
  // ******************************************************************
  typedef enum logic [3:0] {
    DCSTO_ST_LOCKED  = 4'h1,
    DCSTO_ST_RUN     = 4'h2,
    DCSTO_ST_QSTOP   = 4'h4,
    DCSTO_ST_OFF     = 4'h8
  } dcsto_state_type;

  typedef struct packed {
    logic amp_enable;
    logic brake_cmd;
    logic decel_req;
    logic fault;
    logic skew_fault;
  } dcsto_out_type;

endpackage : dcsto_pkg

/* verilog/dcsto_top.sv */
// Purpose: Two-channel safe torque removal with latched fault and restart
//          interlock, plus a fieldbus quick stop ahead of the hard cut.
// Assumes: Inputs synchronous to clk_sys; channel high means drive allowed.
// Notes:   The amplifier cuts one clock after the filter time, far below 50 ms.
//
// Contract
// - Either disable channel alone triggers shutdown.
// - One channel low removes power, raises fault.
// - No braking after shutdown; motor coasts.
// - No restart until fault explicitly reset.
// - Amplifier off under 50 ms after drop.
// - Pulses up to 1 ms are ignored.
// - No standstill monitoring; only torque removed.
// - No automatic restart after power returns.
// - Quick stop request decelerates the drive.
// - Channels drop after delay; drive coasts.
`timescale 1ns/1ns

module dcsto_top
  import dcsto_pkg::*;
#(
  parameter int unsigned FILT_CYCLES = FILT_CYC,
  parameter int unsigned SKEW_CYCLES = SKEW_CYC
) (
  input  wire logic clk_sys,
  input  wire logic rst,
  input  wire logic chan_a_ok,
  input  wire logic chan_b_ok,
  input  wire logic fault_reset,
  input  wire logic enable_req,
  input  wire logic quick_stop_req,
  output logic      amp_enable,
  output logic      brake_cmd,
  output logic      decel_req,
  output logic      fault,
  output logic      skew_fault
);

  // ******************************************************************
  // Channel filters
  // ******************************************************************
  // Each channel has its own counter so neither depends on the other.
  logic [CNT_W-1:0] low_cnt_a_q;
  logic [CNT_W-1:0] low_cnt_b_q;
  logic             trip_a;
  logic             trip_b;
  logic [CNT_W-1:0] skew_cnt_q;
  dcsto_state_type  state_q;
  dcsto_out_type    out_q;
  logic             fault_q;
  logic             skew_q;

  function automatic logic [CNT_W-1:0] bump(input logic [CNT_W-1:0] c,
                                            input logic            low);
    if (!low) begin
      bump = '0;
    end else if (c == {CNT_W{1'b1}}) begin
      bump = c;
    end else begin
      bump = c + 1'b1;
    end
  endfunction : bump

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      low_cnt_a_q <= '0;
      low_cnt_b_q <= '0;
    end else begin
      low_cnt_a_q <= bump(low_cnt_a_q, !chan_a_ok);
      low_cnt_b_q <= bump(low_cnt_b_q, !chan_b_ok);
    end
  end

  // A trip needs a low longer than a test pulse.
  assign trip_a = low_cnt_a_q >= CNT_W'(FILT_CYCLES);
  assign trip_b = low_cnt_b_q >= CNT_W'(FILT_CYCLES);

  // ******************************************************************
  // Channel disagreement watch
  // ******************************************************************
  // Partner switching skew only informs; it never delays the cut.
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      skew_cnt_q <= '0;
    end else begin
      skew_cnt_q <= bump(skew_cnt_q, trip_a != trip_b);
    end
  end

  // ******************************************************************
  // Fault latch
  // ******************************************************************
  // A new trip wins over a reset arriving in the same cycle.
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      fault_q <= 1'b0;
      skew_q  <= 1'b0;
    end else begin
      if (trip_a || trip_b) begin
        fault_q <= 1'b1;
      end else if (fault_reset) begin
        fault_q <= 1'b0;
      end
      if (skew_cnt_q >= CNT_W'(SKEW_CYCLES)) begin
        skew_q <= 1'b1;
      end else if (fault_reset && !(trip_a || trip_b)) begin
        skew_q <= 1'b0;
      end
    end
  end

  // ******************************************************************
  // Operating state
  // ******************************************************************
  // Reset comes up locked: after a power loss the motor stays off until
  // the controller asks for it through enable_req.
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      state_q <= DCSTO_ST_LOCKED;
    end else begin
      unique case (state_q)
        DCSTO_ST_LOCKED: begin
          if (trip_a || trip_b) begin
            state_q <= DCSTO_ST_OFF;
          end else if (enable_req && !fault_q && !fault_reset) begin
            state_q <= DCSTO_ST_RUN;
          end
        end
        DCSTO_ST_RUN: begin
          if (trip_a || trip_b) begin
            state_q <= DCSTO_ST_OFF;
          end else if (quick_stop_req) begin
            state_q <= DCSTO_ST_QSTOP;
          end else if (!enable_req) begin
            state_q <= DCSTO_ST_LOCKED;
          end
        end
        DCSTO_ST_QSTOP: begin
          if (trip_a || trip_b) begin
            state_q <= DCSTO_ST_OFF;
          end else if (!quick_stop_req && !enable_req) begin
            state_q <= DCSTO_ST_LOCKED;
          end
        end
        DCSTO_ST_OFF: begin
          if (!fault_q) begin
            state_q <= DCSTO_ST_LOCKED;
          end
        end
        default: begin
          state_q <= DCSTO_ST_OFF;
        end
      endcase
    end
  end

  // ******************************************************************
  // Outputs
  // ******************************************************************
  // No standstill check exists: the quick stop simply ramps while the
  // amplifier stays powered, and ends on the hard cut or in LOCKED once
  // quick_stop_req and enable_req are both low.
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      out_q <= '0;
    end else begin
      out_q.amp_enable <= (state_q == DCSTO_ST_RUN ||
                           state_q == DCSTO_ST_QSTOP) &&
                          !trip_a && !trip_b && !fault_q;
      out_q.brake_cmd  <= 1'b0;
      out_q.decel_req  <= state_q == DCSTO_ST_QSTOP &&
                          !trip_a && !trip_b;
      out_q.fault      <= fault_q || trip_a || trip_b;
      out_q.skew_fault <= skew_q;
    end
  end

  assign amp_enable = out_q.amp_enable;
  assign brake_cmd  = out_q.brake_cmd;
  assign decel_req  = out_q.decel_req;
  assign fault      = out_q.fault;
  assign skew_fault = out_q.skew_fault;

endmodule : dcsto_top
